/* File: irq_timebase_defs.svh */
// Offsets, field positions, reset values and counts of the interrupt block.
// Assumes inclusion by bare name; definitions only.
`ifndef IRQ_TIMEBASE_DEFS_SVH
`define IRQ_TIMEBASE_DEFS_SVH
`define ADDR_TIME_BASE_CONTROL 4'h0
`define ADDR_INT_CONTROL 4'h1
`define ADDR_GROUP_ENABLE 4'h2
`define ADDR_GROUP_FLAGS 4'h3
`define ADDR_SOURCE_FLAGS 4'h4
`define ADDR_SOURCE_ENABLE 4'h5
`define ADDR_SOURCE_MAP_BASE 4'h8
`define TBC_RESET 8'h37
`define TBC_ON_BIT 7
`define TBC_CLK_BIT 6
`define TBC_P1_HI 5
`define TBC_P1_LO 4
`define TBC_LP_BIT 3
`define TBC_P0_HI 2
`define TBC_P0_LO 0
`define ICTL_GIE_BIT 0
`define ICTL_CONV_EN_BIT 1
`define ICTL_P0_EN_BIT 2
`define ICTL_P1_EN_BIT 3
`define ICTL_CONV_FLAG_BIT 4
`define ICTL_P0_FLAG_BIT 5
`define ICTL_P1_FLAG_BIT 6
`define ICTL_RESET 8'h00
`define SYS_DIV_COUNT 2'h3
`define P0_BASE_SHIFT 8
`define P1_BASE_SHIFT 12
`define NUM_GROUPS 6
`define NUM_SOURCES 8
`define VEC_CONV 4'h1
`define VEC_P0 4'h2
`define VEC_P1 4'h3
`define VEC_GROUP_BASE 4'h4
`endif

/* File: irq_timebase_pkg.sv */
// Types shared by the interrupt and time-base block.
// Takes no numbers from the defs header; encodings and widths are given here.
package irq_timebase_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_call = 2'b01
  } ack_state_t;
  typedef logic [15:0] period_count_t;
endpackage

/* File: source_map_mem.sv */
// Small register file holding the group membership of each source.
// Assumes one clock domain; read data comes from a register.
`timescale 1ns/1ps
`default_nettype none
module source_map_mem (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic write_in,
  input wire logic [2:0] write_index_in,
  input wire logic [7:0] write_data_in,
  input wire logic [2:0] read_index_in,
  output logic [7:0] read_data_out,
  output logic [63:0] all_maps_out
);
  logic [7:0] map_words [0:7];
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 8; i++) begin
        map_words[i] <= 8'h00;
      end
    end else if (write_in) begin
      map_words[write_index_in] <= write_data_in;
    end
  end
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      read_data_out <= 8'h00;
    end else begin
      read_data_out <= map_words[read_index_in];
    end
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      all_maps_out[i*8 +: 8] = map_words[i];
    end
  end
endmodule // source_map_mem
`default_nettype wire

/* File: irq_timebase.sv */
// Grouped interrupts, converter-done interrupt and two time-base interrupts.
// Assumes the CPU asserts ack_in for one cycle when it takes a call.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "irq_timebase_defs.svh"
module irq_timebase
  import irq_timebase_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  input wire logic [7:0] source_set_in,
  input wire logic conv_done_in,
  input wire logic period_dedicated_clock_in,
  input wire logic stack_full_in,
  input wire logic ack_in,
  output logic irq_out,
  output logic [3:0] vector_out,
  output logic wake_out,
  output logic slow_xtal_low_power_out,
  output logic interrupt_out
);
  logic [7:0] time_base_control;
  logic [7:0] int_control;
  logic [5:0] group_request_flags;
  logic [5:0] group_enable;
  logic [7:0] source_flags;
  logic [7:0] source_enable;
  logic [63:0] all_maps;
  logic [7:0] map_rdata;
  logic map_read_q;
  logic [7:0] reg_rdata;
  logic [7:0] reg_rdata_q;
  logic tb_sync1, tb_sync2, tb_sync3, tb_level;
  logic [1:0] sys_div;
  logic tick;
  period_count_t period_count;
  logic p0_ovf, p1_ovf;
  logic [5:0] group_set;
  logic [7:0] src_rise;
  logic take;
  logic [3:0] next_vector;
  logic pending;
  logic [16:0] flags_all, flags_prev;
  ack_state_t state;
  logic global_irq_enable, conv_done_flag, conv_done_irq_enable;
  logic period0_request_flag, period1_request_flag;
  logic period0_irq_enable, period1_irq_enable;
  logic period_gen_on, period_clock_select;
  logic [1:0] period1_length_sel;
  logic [2:0] period0_length_sel;
  logic map_write;

  function automatic logic is_wr(input logic [3:0] a, input logic [3:0] o);
    is_wr = write_in && (a == o);
  endfunction

  assign global_irq_enable = int_control[`ICTL_GIE_BIT];
  assign conv_done_irq_enable = int_control[`ICTL_CONV_EN_BIT];
  assign period0_irq_enable = int_control[`ICTL_P0_EN_BIT];
  assign period1_irq_enable = int_control[`ICTL_P1_EN_BIT];
  assign conv_done_flag = int_control[`ICTL_CONV_FLAG_BIT];
  assign period0_request_flag = int_control[`ICTL_P0_FLAG_BIT];
  assign period1_request_flag = int_control[`ICTL_P1_FLAG_BIT];
  assign period_gen_on = time_base_control[`TBC_ON_BIT];
  assign period_clock_select = time_base_control[`TBC_CLK_BIT];
  assign period1_length_sel = time_base_control[`TBC_P1_HI:`TBC_P1_LO];
  assign period0_length_sel = time_base_control[`TBC_P0_HI:`TBC_P0_LO];
  assign slow_xtal_low_power_out = time_base_control[`TBC_LP_BIT];
  assign map_write = write_in && addr_in[3];

  source_map_mem u_map (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .write_in(map_write),
    .write_index_in(addr_in[2:0]),
    .write_data_in(wdata_in),
    .read_index_in(addr_in[2:0]),
    .read_data_out(map_rdata),
    .all_maps_out(all_maps)
  );

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      time_base_control <= `TBC_RESET;
    end else if (is_wr(addr_in, `ADDR_TIME_BASE_CONTROL)) begin
      time_base_control <= wdata_in;
    end
  end

  // Dedicated clock arrives from outside; three-stage sampling
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tb_sync1 <= 1'b0;
      tb_sync2 <= 1'b0;
      tb_sync3 <= 1'b0;
      tb_level <= 1'b0;
    end else begin
      tb_sync1 <= period_dedicated_clock_in;
      tb_sync2 <= tb_sync1;
      tb_sync3 <= tb_sync2;
      if (tb_sync2 == tb_sync3) begin
        tb_level <= tb_sync3;
      end
    end
  end

  // Free running; periods on this clock are exact multiples of four
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sys_div <= 2'h0;
    end else begin
      sys_div <= (sys_div == `SYS_DIV_COUNT) ? 2'h0 : sys_div + 2'h1;
    end
  end

  // Edge of the dedicated clock only counts once both later stages agree
  always_comb begin
    if (period_clock_select) begin
      tick = (sys_div == `SYS_DIV_COUNT);
    end else begin
      tick = tb_sync2 && tb_sync3 && !tb_level;
    end
  end

  // Shared counter; the bit at each selected length and all bits below it, all set, flag the overflow
  // Switching the generator off restarts every period from zero
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      period_count <= 16'h0000;
    end else if (!period_gen_on) begin
      period_count <= 16'h0000;
    end else if (tick) begin
      period_count <= period_count + 16'h0001;
    end
  end

  function automatic logic ovf_at(input period_count_t c, input int sh);
    ovf_at = (c[sh +: 1] == 1'b1) && ((c & ((16'h0001 << sh) - 16'h0001))
             == ((16'h0001 << sh) - 16'h0001));
  endfunction

  assign p0_ovf = period_gen_on && tick &&
    ovf_at(period_count, `P0_BASE_SHIFT - 1 + int'(period0_length_sel)) ==
    1'b1 ? 1'b1 : 1'b0;
  assign p1_ovf = period_gen_on && tick &&
    ovf_at(period_count, `P1_BASE_SHIFT - 1 + int'(period1_length_sel)) ==
    1'b1 ? 1'b1 : 1'b0;

  // Sources: timer, serial, pin, voltage, memory flags mapped into groups
  assign src_rise = source_set_in & ~source_flags;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      source_flags <= 8'h00;
      source_enable <= 8'h00;
    end else begin
      // Set wins over the write-one clear; group service never clears these
      if (is_wr(addr_in, `ADDR_SOURCE_FLAGS)) begin
        source_flags <= (source_flags & ~wdata_in) | source_set_in;
      end else begin
        source_flags <= source_flags | source_set_in;
      end
      if (is_wr(addr_in, `ADDR_SOURCE_ENABLE)) begin
        source_enable <= wdata_in;
      end
    end
  end

  // Only a rising source counts, so a held source cannot refire its group
  always_comb begin
    for (int g = 0; g < `NUM_GROUPS; g++) begin
      group_set[g] = 1'b0;
      for (int s = 0; s < `NUM_SOURCES; s++) begin
        group_set[g] = group_set[g] |
          (src_rise[s] & source_enable[s] & all_maps[s*8 + g]);
      end
    end
  end

  // Fixed priority: converter, period 0, period 1, then groups upward
  always_comb begin
    next_vector = 4'h0;
    pending = 1'b0;
    if (conv_done_flag && conv_done_irq_enable) begin
      next_vector = `VEC_CONV;
      pending = 1'b1;
    end else if (period0_request_flag && period0_irq_enable) begin
      next_vector = `VEC_P0;
      pending = 1'b1;
    end else if (period1_request_flag && period1_irq_enable) begin
      next_vector = `VEC_P1;
      pending = 1'b1;
    end else begin
      for (int g = `NUM_GROUPS - 1; g >= 0; g--) begin
        if (group_request_flags[g] && group_enable[g]) begin
          next_vector = `VEC_GROUP_BASE + 4'(g);
          pending = 1'b1;
        end
      end
    end
  end

  // Request withdrawn at once while stack full or global enable clear,
  // so the CPU can never take a call that the state register still holds
  assign irq_out = (state == st_call) && global_irq_enable &&
                   !stack_full_in;
  assign take = irq_out && ack_in;

  // Vector is frozen on entry; a later, higher request waits its turn
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= st_idle;
      vector_out <= 4'h0;
    end else begin
      unique case (state)
        st_idle: begin
          if (pending && global_irq_enable && !stack_full_in) begin
            state <= st_call;
            vector_out <= next_vector;
          end
        end
        st_call: begin
          if (ack_in || !global_irq_enable || stack_full_in) begin
            state <= st_idle;
          end
        end
      endcase
    end
  end

  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      int_control <= `ICTL_RESET;
    end else begin
      // A write in the cycle of a take keeps the written enables
      if (is_wr(addr_in, `ADDR_INT_CONTROL)) begin
        int_control[3:0] <= wdata_in[3:0];
      end else if (take) begin
        int_control[`ICTL_GIE_BIT] <= 1'b0;
      end
      int_control[`ICTL_CONV_FLAG_BIT] <= flag_next(conv_done_flag,
        conv_done_in,
        (take && vector_out == `VEC_CONV) ||
        (is_wr(addr_in, `ADDR_INT_CONTROL) && wdata_in[4]));
      int_control[`ICTL_P0_FLAG_BIT] <= flag_next(period0_request_flag,
        p0_ovf,
        (take && vector_out == `VEC_P0) ||
        (is_wr(addr_in, `ADDR_INT_CONTROL) && wdata_in[5]));
      int_control[`ICTL_P1_FLAG_BIT] <= flag_next(period1_request_flag,
        p1_ovf,
        (take && vector_out == `VEC_P1) ||
        (is_wr(addr_in, `ADDR_INT_CONTROL) && wdata_in[6]));
      int_control[7] <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      group_request_flags <= 6'h00;
      group_enable <= 6'h00;
    end else begin
      for (int g = 0; g < `NUM_GROUPS; g++) begin
        group_request_flags[g] <= flag_next(group_request_flags[g],
          group_set[g],
          (take && vector_out == `VEC_GROUP_BASE + 4'(g)) ||
          (is_wr(addr_in, `ADDR_GROUP_FLAGS) && wdata_in[g]));
      end
      if (is_wr(addr_in, `ADDR_GROUP_ENABLE)) begin
        group_enable <= wdata_in[5:0];
      end
    end
  end

  // Wake on any rising flag, ignoring enables
  // Every flag keeps a bit of its own so no rise hides behind another
  assign flags_all = {source_flags, group_request_flags, period1_request_flag,
                      period0_request_flag, conv_done_flag};
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_prev <= 17'h00000;
      wake_out <= 1'b0;
    end else begin
      flags_prev <= flags_all;
      wake_out <= |(flags_all & ~flags_prev);
    end
  end

  // Level of any unmasked converter, period or group flag, whatever the global enable says
  assign interrupt_out = pending;

  always_comb begin
    unique case (addr_in)
      `ADDR_TIME_BASE_CONTROL: reg_rdata = time_base_control;
      `ADDR_INT_CONTROL: reg_rdata = int_control;
      `ADDR_GROUP_ENABLE: reg_rdata = {2'h0, group_enable};
      `ADDR_GROUP_FLAGS: reg_rdata = {2'h0, group_request_flags};
      `ADDR_SOURCE_FLAGS: reg_rdata = source_flags;
      `ADDR_SOURCE_ENABLE: reg_rdata = source_enable;
      default: reg_rdata = 8'h00;
    endcase
  end

  // Map words already sit in the memory's output register; other reads
  // are registered here, so both stand in the cycle after the strobe
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      map_read_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end else begin
      map_read_q <= read_in && addr_in[3];
      reg_rdata_q <= read_in ? reg_rdata : 8'h00;
    end
  end
  assign rdata_out = map_read_q ? map_rdata : reg_rdata_q;
endmodule // irq_timebase
`default_nettype wire

/* File: irq_timebase_checker.sv */
// Port assertions for the interrupt and time-base block.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module irq_timebase_checker (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [7:0] rdata_out,
  input wire logic stack_full_in,
  input wire logic ack_in,
  input wire logic irq_out,
  input wire logic [3:0] vector_out,
  input wire logic slow_xtal_low_power_out,
  input wire logic interrupt_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  AST_IRQ_COPY: assert property (
    $rose(irq_out) |-> $past(interrupt_out))
    else $error("call raised without an unmasked flag");
  AST_FULL_BLOCK: assert property (
    stack_full_in |-> !irq_out)
    else $error("call raised while stack full");
  AST_ACK_DROP: assert property (
    irq_out && ack_in |=> !irq_out)
    else $error("call stands after ack");
  AST_GIE_HOLD: assert property (
    (irq_out && ack_in) ##1 !write_in [*2] |=> !irq_out)
    else $error("call without global enable");
  AST_VEC_VALID: assert property (
    irq_out |-> vector_out inside {[4'h1:4'h9]})
    else $error("vector out of range");
  AST_RDATA_IDLE: assert property (!$past(read_in) |-> rdata_out == 8'h00)
    else $error("read data outside read reply");
  AST_LP_FOLLOWS: assert property (
    write_in && addr_in == 4'h0 |=>
    slow_xtal_low_power_out == $past(wdata_in[3]))
    else $error("low power bit not written");
  AST_LP_READ: assert property (
    read_in && addr_in == 4'h0 |=> rdata_out[3] == slow_xtal_low_power_out)
    else $error("low power bit read back wrong");
  AST_IRQ_STANDS: assert property (
    irq_out && !ack_in && !write_in ##1 !stack_full_in |-> irq_out)
    else $error("call dropped without cause");
  AST_UNMAPPED: assert property (
    read_in && addr_in inside {4'h6, 4'h7} |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule // irq_timebase_checker
bind irq_timebase irq_timebase_checker chk (
  .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
  .rdata_out(rdata_out), .stack_full_in(stack_full_in), .ack_in(ack_in),
  .irq_out(irq_out), .vector_out(vector_out),
  .slow_xtal_low_power_out(slow_xtal_low_power_out),
  .interrupt_out(interrupt_out));
`default_nettype wire

/* File: cpu_partner.sv */
// CPU core model taking calls from the interrupt block.
// Assumes ack is a one-cycle pulse after a chosen wait.
`timescale 1ns/1ps
`default_nettype none
module cpu_partner (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic irq_in,
  input wire logic [3:0] delay_in,
  output logic ack_out
);
  logic [3:0] wait_cnt;
  // Acks only a request still standing, once per call
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_out <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      ack_out <= 1'b0;
      wait_cnt <= 4'h0;
      if (irq_in && !ack_out) begin
        if (wait_cnt >= delay_in) begin
          ack_out <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule // cpu_partner
`default_nettype wire

/* File: multifunction_irq_and_timebase_bench.sv */
// Self-checking bench for the interrupt and time-base block.
// Assumes 20 MHz clock; the CPU model answers calls.
`timescale 1ns/1ps
`default_nettype none
`include "irq_timebase_defs.svh"
module multifunction_irq_and_timebase_bench;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] en;
    logic [7:0] fm;
    logic [3:0] vec;
    logic [31:0] span;
  } row_t;
  // Span is ticks times clocks per tick (4 for fsys/4, 8 for pin)
  row_t rows [4] = '{
    '{8'hC0, 8'h05, 8'h20, `VEC_P0, 32'd4 << 8},
    '{8'hC2, 8'h05, 8'h20, `VEC_P0, 32'd4 << 10},
    '{8'h80, 8'h05, 8'h20, `VEC_P0, 32'd8 << 8},
    '{8'hC0, 8'h09, 8'h40, `VEC_P1, 32'd4 << 12}};
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic [7:0] source_set_in = 8'h00;
  logic conv_done_in = 1'b0;
  logic ded_clk = 1'b0;
  logic stack_full_in = 1'b0;
  logic [3:0] delay = 4'h0;
  logic [7:0] rdata_out;
  logic ack_in, irq_out, wake_out, lp_out, int_out;
  logic [3:0] vector_out, seen_vec;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  irq_timebase uut (.clock_in(clock_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
    .read_in(read_in), .rdata_out(rdata_out),
    .source_set_in(source_set_in), .conv_done_in(conv_done_in),
    .period_dedicated_clock_in(ded_clk), .stack_full_in(stack_full_in),
    .ack_in(ack_in), .irq_out(irq_out), .vector_out(vector_out),
    .wake_out(wake_out), .slow_xtal_low_power_out(lp_out),
    .interrupt_out(int_out));
  cpu_partner cpu (.clock_in(clock_in), .rstn_in(rstn_in),
    .irq_in(irq_out), .delay_in(delay), .ack_out(ack_in));
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  // Pin clock of 8 system clocks, changed on the edge like all inputs
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    ded_clk <= cyc[2];
    if (cyc == 90000) begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    @(negedge clock_in);
    d = rdata_out;
    @(posedge clock_in);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a,
                     input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(nm, exp, d);
  endtask
  // Bounded wait for the call line; t is -1 if it never came
  task automatic wait_irq(input logic v, input int lim, output int t);
    int k;
    k = 0;
    @(negedge clock_in);
    while (irq_out !== v && k < lim) begin
      @(negedge clock_in);
      k++;
    end
    t = (k < lim) ? cyc : -1;
    seen_vec = vector_out;
    @(posedge clock_in);
  endtask
  initial begin
    int t1, t2, k;
    logic [7:0] d;
    repeat (4) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    foreach (rows[i]) begin
      wr(`ADDR_TIME_BASE_CONTROL, rows[i].ctl);
      wr(`ADDR_INT_CONTROL, 8'h70 | rows[i].en);
      wait_irq(1'b1, 2 * rows[i].span, t1);
      wait_irq(1'b0, 20, k);
      rd(`ADDR_INT_CONTROL, d);
      chk("flag", rows[i].en & 8'h0E, d & (8'h0F | rows[i].fm));
      wr(`ADDR_INT_CONTROL, rows[i].en);
      wait_irq(1'b1, 2 * rows[i].span, t2);
      chk("vector", rows[i].vec, seen_vec);
      chk("period", rows[i].span, t2 - t1);
      wait_irq(1'b0, 20, k);
    end
    wr(`ADDR_TIME_BASE_CONTROL, 8'h08);
    chk("low power", 1, lp_out);
    wr(`ADDR_INT_CONTROL, 8'h7D);
    wait_irq(1'b1, 1200, t1);
    chk("stopped", -1, t1);
    delay <= 4'h5;
    wr(`ADDR_INT_CONTROL, 8'h72);
    conv_done_in <= 1'b1;
    @(posedge clock_in);
    conv_done_in <= 1'b0;
    k = 0;
    repeat (4) begin
      @(negedge clock_in);
      if (wake_out === 1'b1) k++;
    end
    chk("wake", 1, k);
    @(posedge clock_in);
    rdc("conv flag", `ADDR_INT_CONTROL, 8'h12);
    chk("no call", 0, irq_out);
    chk("level irq", 1, int_out);
    stack_full_in <= 1'b1;
    wr(`ADDR_INT_CONTROL, 8'h03);
    wait_irq(1'b1, 20, t1);
    chk("stack full", -1, t1);
    stack_full_in <= 1'b0;
    wait_irq(1'b1, 10, t1);
    chk("conv vector", `VEC_CONV, seen_vec);
    stack_full_in <= 1'b1;
    @(negedge clock_in);
    chk("full withdraws", 0, irq_out);
    @(posedge clock_in);
    stack_full_in <= 1'b0;
    wait_irq(1'b1, 10, t1);
    chk("conv again", `VEC_CONV, seen_vec);
    wait_irq(1'b0, 20, k);
    rdc("conv clear", `ADDR_INT_CONTROL, 8'h02);
    delay <= 4'h0;
    wr(`ADDR_SOURCE_ENABLE, 8'hFF);
    for (int g = 0; g < `NUM_GROUPS; g++) begin
      wr(`ADDR_SOURCE_MAP_BASE + 4'(g), 8'h01 << g);
      rdc("map", `ADDR_SOURCE_MAP_BASE + 4'(g), 8'h01 << g);
      wr(`ADDR_GROUP_ENABLE, 8'h01 << g);
      wr(`ADDR_INT_CONTROL, 8'h01);
      source_set_in <= 8'h01 << g;
      @(posedge clock_in);
      source_set_in <= 8'h00;
      wait_irq(1'b1, 10, t1);
      chk("grp vector", `VEC_GROUP_BASE + g, seen_vec);
      wait_irq(1'b0, 20, k);
      rdc("grp flag", `ADDR_GROUP_FLAGS, 8'h00);
      rdc("global", `ADDR_INT_CONTROL, 8'h00);
      rdc("src kept", `ADDR_SOURCE_FLAGS, 8'h01 << g);
      wr(`ADDR_SOURCE_FLAGS, 8'h01 << g);
      rdc("src clear", `ADDR_SOURCE_FLAGS, 8'h00);
    end
    rstn_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    chk("reset irq", 0, irq_out);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    chk("reset lp", 0, lp_out);
    rdc("ctl reset", `ADDR_TIME_BASE_CONTROL, 8'h37);
    rdc("int reset", `ADDR_INT_CONTROL, `ICTL_RESET);
    wr(4'h6, 8'hFF);
    rdc("unmapped", 4'h6, 8'h00);
    stop_test();
  end
endmodule // multifunction_irq_and_timebase_bench
`default_nettype wire
